//--- fppc_consts.svh
/*
 flash pin protect control: offsets, field positions, codes and reset values.
 assumes inclusion by the package and the top module only.
*/
`ifndef FPPC_CONSTS_SVH
`define FPPC_CONSTS_SVH

`define FPPC_START_CODE 4'h0
`define FPPC_CYC_MEM 2'h1
`define FPPC_TAR_NIBBLE 4'hf
`define FPPC_SYNC_READY 4'h0
`define FPPC_ADDR_LAST 3'h7
`define FPPC_DATA_LAST 3'h1
`define FPPC_ID_LSB 23
`define FPPC_ID_MSB 26
`define FPPC_REG_SPACE_BIT 22
`define FPPC_BLK_LSB 16
`define FPPC_BLK_MSB 18
`define FPPC_BOOT_BLOCK 3'h7
`define FPPC_BOOT_ID 4'h0
`define FPPC_GPI_OFS_MSB 7
`define FPPC_GPI_OFS 8'h80
`define FPPC_ROW_BITS 11
`define FPPC_COL_BITS 8
`define FPPC_RST_ADDR 32'h0000_0000
`define FPPC_RST_BYTE 8'h00

`endif

//--- fppc_pkg.sv
/*
 flash pin protect control: shared types.
 assumes fppc_consts.svh sits in the same folder.
*/
`include "fppc_consts.svh"

package fppc_pkg;

   typedef enum logic [3:0] {
      FPPC_S_IDLE, FPPC_S_TYPE, FPPC_S_ADDR, FPPC_S_WDATA, FPPC_S_TAR0,
      FPPC_S_TAR1, FPPC_S_SYNC, FPPC_S_RDATA, FPPC_S_TARE0, FPPC_S_TARE1
   } fppc_state_t;

   // request handed to the array core
   typedef struct packed {
      logic [18:0] addr;
      logic [7:0] data;
   } fppc_mem_req_t;

   // one direction of the four-bit bus as the device drives it
   typedef struct packed {
      logic [3:0] data;
      logic oe;
   } fppc_lad_drv_t;

endpackage

//--- fppc_ctrl.sv
/*
 flash pin protect control: bus cycle framing, hardware write protection,
 merged reset, strap capture and general input readback, multiplexed address
 latching and ready/busy. assumes an array core that answers reads one
 cycle after mem_rd_req and reports core_busy while programming.
*/
// Overview of operation
// - either reset input low resets the whole device
// - four-bit identity strap selects device; strap 0000 marks the boot device
// - five general input levels are readable by the host through a register
// - top-block lock low refuses every boot block program or erase
// - top-block lock high permits every boot block program or erase
// - array protect low refuses writes to all but the highest block
// - frame asserted marks the start of a new bus cycle
// - frame asserted mid-cycle aborts the cycle in progress
// - row/column select says whether address pins carry row or column
// - ready/busy shows a running internal write, valid in programmer mode
// - bus mode moves addresses, commands and data over four bus lines
// - interface select high gives programmer mode, fixed at reset exit
// - abort ends only the bus cycle; internal write runs until reset
`timescale 1ns/10ps
`include "fppc_consts.svh"

module fppc_ctrl
(
   // clock and resets
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic init_n,
   // straps and board inputs
   input wire logic mode_sel,
   input wire logic [3:0] chip_identity_strap,
   input wire logic [4:0] general_input_pins,
   input wire logic top_block_lock_in,
   input wire logic write_protect_n,
   // four-bit bus
   input wire logic frame_n,
   input wire logic [3:0] lad_in,
   output fppc_pkg::fppc_lad_drv_t lad_drv,
   // multiplexed programmer pins
   input wire logic row_col_sel,
   input wire logic [10:0] mux_addr_pins,
   output logic [18:0] mux_addr,
   output logic ready_busy,
   // array core side
   output fppc_pkg::fppc_mem_req_t mem_req,
   output logic mem_rd_req,
   input wire logic [7:0] mem_rdata,
   output logic prog_req,
   output logic write_refused,
   input wire logic core_busy,
   output logic core_reset_n,
   output logic boot_device,
   output logic mux_mode
);
   import fppc_pkg::*;

   logic [1:0] rst_pipe;
   logic rst_n;
   logic rst_in_n;
   logic captured;
   logic [3:0] strap;
   fppc_state_t state;
   fppc_state_t next_state;
   logic [2:0] nib;
   logic is_write;
   logic [31:0] addr;
   logic [31:0] next_addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic selected;
   logic reg_space;
   logic boot_hit;
   logic permitted;
   fppc_lad_drv_t next_lad;

   assign rst_in_n = reset_n & init_n;
   always_ff @(posedge mclk or negedge rst_in_n)
   begin
      if (!rst_in_n)
         rst_pipe <= 2'h0;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_n = rst_pipe[1];
   // core program/erase stops only on reset
   assign core_reset_n = rst_n;

   // mode and strap caught once after release
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         captured <= 1'b0;
         mux_mode <= 1'b0;
         strap <= 4'h0;
      end
      else if (!captured)
      begin
         captured <= 1'b1;
         mux_mode <= mode_sel;
         strap <= chip_identity_strap;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         boot_device <= 1'b0;
      else
         boot_device <= captured && (strap == `FPPC_BOOT_ID);
   end

   assign next_addr = {addr[27:0], lad_in};
   // cycle claimed only when the address carries our identity
   assign selected = captured &&
      (next_addr[`FPPC_ID_MSB:`FPPC_ID_LSB] == strap);
   assign reg_space = addr[`FPPC_REG_SPACE_BIT];
   assign boot_hit = (addr[`FPPC_BLK_MSB:`FPPC_BLK_LSB] == `FPPC_BOOT_BLOCK);
   assign permitted = boot_hit ? top_block_lock_in : write_protect_n;

   always_comb
   begin
      next_state = state;
      if (mux_mode || !captured)
         next_state = FPPC_S_IDLE;
      // frame low restarts; only the last start nibble counts
      else if (!frame_n)
         next_state = (lad_in == `FPPC_START_CODE) ? FPPC_S_TYPE :
            FPPC_S_IDLE;
      else
         unique case (state)
            FPPC_S_IDLE: next_state = FPPC_S_IDLE;
            FPPC_S_TYPE:
               next_state = (lad_in[3:2] == `FPPC_CYC_MEM) ? FPPC_S_ADDR :
                  FPPC_S_IDLE;
            FPPC_S_ADDR:
               if (nib == `FPPC_ADDR_LAST)
                  next_state = !selected ? FPPC_S_IDLE :
                     (is_write ? FPPC_S_WDATA : FPPC_S_TAR0);
            FPPC_S_WDATA:
               if (nib == `FPPC_DATA_LAST)
                  next_state = FPPC_S_TAR0;
            FPPC_S_TAR0: next_state = FPPC_S_TAR1;
            FPPC_S_TAR1: next_state = FPPC_S_SYNC;
            FPPC_S_SYNC:
               next_state = is_write ? FPPC_S_TARE0 : FPPC_S_RDATA;
            FPPC_S_RDATA:
               if (nib == `FPPC_DATA_LAST)
                  next_state = FPPC_S_TARE0;
            FPPC_S_TARE0: next_state = FPPC_S_TARE1;
            FPPC_S_TARE1: next_state = FPPC_S_IDLE;
         endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= FPPC_S_IDLE;
         nib <= 3'h0;
      end
      else
      begin
         state <= next_state;
         nib <= (next_state == state) ? nib + 3'h1 : 3'h0;
      end
   end

   // address, type and write data collected from the bus lines
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         is_write <= 1'b0;
         addr <= `FPPC_RST_ADDR;
         wdata <= `FPPC_RST_BYTE;
      end
      else
      begin
         if (state == FPPC_S_TYPE)
            is_write <= lad_in[1];
         if (state == FPPC_S_ADDR)
            addr <= next_addr;
         // data arrives low nibble first
         if (state == FPPC_S_WDATA && nib == 3'h0)
            wdata[3:0] <= lad_in;
         if (state == FPPC_S_WDATA && nib == `FPPC_DATA_LAST)
            wdata[7:4] <= lad_in;
      end
   end

   // refused writes raise no program request
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prog_req <= 1'b0;
         write_refused <= 1'b0;
         mem_rd_req <= 1'b0;
         mem_req <= '0;
      end
      else
      begin
         prog_req <= (state == FPPC_S_WDATA) && (next_state == FPPC_S_TAR0) &&
            !reg_space && permitted;
         write_refused <= (state == FPPC_S_WDATA) &&
            (next_state == FPPC_S_TAR0) && !reg_space && !permitted;
         // reads reach TAR0 straight from the last address nibble
         mem_rd_req <= (next_state == FPPC_S_TAR0) && !is_write &&
            !next_addr[`FPPC_REG_SPACE_BIT];
         if (next_state == FPPC_S_TAR0)
         begin
            mem_req.addr <= (state == FPPC_S_ADDR) ? next_addr[18:0] :
               addr[18:0];
            mem_req.data <= {lad_in, wdata[3:0]};
         end
      end
   end

   // general inputs sampled inside the read cycle itself
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= `FPPC_RST_BYTE;
      else if (state == FPPC_S_TAR1)
      begin
         if (reg_space && addr[`FPPC_GPI_OFS_MSB:0] == `FPPC_GPI_OFS)
            rdata <= {3'h0, general_input_pins};
         else if (reg_space)
            rdata <= `FPPC_RST_BYTE;
         else
            rdata <= mem_rdata;
      end
   end

   // bus drive chosen from next state so outputs come from flops
   always_comb
   begin
      next_lad.oe = 1'b1;
      next_lad.data = `FPPC_TAR_NIBBLE;
      unique case (next_state)
         FPPC_S_TAR1, FPPC_S_TARE0: next_lad.data = `FPPC_TAR_NIBBLE;
         FPPC_S_SYNC: next_lad.data = `FPPC_SYNC_READY;
         FPPC_S_RDATA:
            next_lad.data = (state == FPPC_S_SYNC) ? rdata[3:0] : rdata[7:4];
         default: next_lad.oe = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         lad_drv <= '0;
      else
         lad_drv <= next_lad;
   end

   // row while select high, column while low; column is the top part
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         mux_addr <= 19'h0_0000;
      else if (mux_mode && row_col_sel)
         mux_addr[`FPPC_ROW_BITS-1:0] <= mux_addr_pins;
      else if (mux_mode)
         mux_addr[18:`FPPC_ROW_BITS] <= mux_addr_pins[`FPPC_COL_BITS-1:0];
   end

   // ready high when idle; held ready in bus mode
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ready_busy <= 1'b1;
      else
         ready_busy <= !(mux_mode && core_busy);
   end

   default clocking chk_clk @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence wr_done;
      state == FPPC_S_WDATA && next_state == FPPC_S_TAR0 && !reg_space;
   endsequence

   sequence frame_start;
      !frame_n && lad_in == `FPPC_START_CODE && !mux_mode && captured;
   endsequence

   chk_boot_refuse: assert property (
      wr_done and (boot_hit && !top_block_lock_in) |=> !prog_req && write_refused)
      else $error("boot block write taken while lock low");
   chk_array_refuse: assert property (
      wr_done and (!boot_hit && !write_protect_n) |=> !prog_req && write_refused)
      else $error("array write taken while protect low");
   chk_boot_open: assert property (
      wr_done and (boot_hit && top_block_lock_in) |=> prog_req)
      else $error("boot block write refused while lock high");
   chk_frame_start: assert property (
      frame_start |=> state == FPPC_S_TYPE)
      else $error("start nibble under frame not taken");
   chk_abort_cycle: assert property (
      (state != FPPC_S_IDLE && !frame_n && lad_in != `FPPC_START_CODE)
      |=> state == FPPC_S_IDLE && !lad_drv.oe)
      else $error("frame did not abort cycle");
   chk_gpi_read: assert property (
      (state == FPPC_S_TAR1 && reg_space && frame_n &&
      addr[`FPPC_GPI_OFS_MSB:0] == `FPPC_GPI_OFS)
      ##1 frame_n |=> lad_drv.data == rdata[3:0] &&
      rdata == {3'h0, $past(general_input_pins, 2)})
      else $error("general input readback wrong");
   chk_rb_track: assert property (
      mux_mode && core_busy |=> !ready_busy)
      else $error("ready/busy missed a running write");
   chk_mode_hold: assert property (
      captured |=> $stable(mux_mode) && $stable(strap))
      else $error("mode changed after reset exit");
   chk_abort_keeps: assert property (
      !frame_n |=> core_reset_n)
      else $error("abort disturbed the internal write");
   chk_no_refused: assert property (
      write_refused |-> !prog_req)
      else $error("refused write started programming");
   chk_row_latch: assert property (
      mux_mode && row_col_sel |=> mux_addr[10:0] == $past(mux_addr_pins))
      else $error("row address not latched");
   chk_sync_nibble: assert property (
      state == FPPC_S_TAR1 && frame_n && !mux_mode
      |=> lad_drv.oe && lad_drv.data == `FPPC_SYNC_READY)
      else $error("sync nibble missing");

endmodule // fppc_ctrl

//--- fppc_host.sv
/*
 host bus controller model: frames read and write cycles on the nibble bus.
 assumes the bench resolves the wire, pulled up to 1111 when undriven.
*/
`timescale 1ns/10ps

module fppc_host
(
   // clock
   input wire logic mclk,
   // four-bit bus
   output logic frame_n,
   output logic [3:0] hd,
   output logic hoe,
   input wire logic [3:0] lad
);
   initial
   begin
      frame_n = 1'b1;
      hd = 4'h0;
      hoe = 1'b0;
   end

   // rd[8] set once a sync nibble was seen; ab picks the aborted nibble
   task automatic cyc(input logic wr, input logic [31:0] a,
      input logic [7:0] d, input int ab, output logic [8:0] rd);
      int i;
      rd = 9'h0;
      @(negedge mclk);
      frame_n = 1'b0;
      hoe = 1'b1;
      hd = 4'h0;
      @(negedge mclk);
      frame_n = 1'b1;
      hd = {2'b01, wr, 1'b0};
      for (i = 7; i >= 0; i--)
      begin
         @(negedge mclk);
         if (7 - i == ab)
         begin
            frame_n = 1'b0;
            hd = 4'hf;
            @(negedge mclk);
            frame_n = 1'b1;
            hoe = 1'b0;
            return;
         end
         hd = a[i*4 +: 4];
      end
      if (wr)
      begin
         @(negedge mclk);
         hd = d[3:0];
         @(negedge mclk);
         hd = d[7:4];
      end
      @(negedge mclk);
      hd = 4'hf;
      @(negedge mclk);
      hoe = 1'b0;
      for (i = 0; i < 8 && !rd[8]; i++)
      begin
         @(negedge mclk);
         if (lad === 4'h0)
         begin
            rd[8] = 1'b1;
            if (!wr)
            begin
               @(negedge mclk);
               rd[3:0] = lad;
               @(negedge mclk);
               rd[7:4] = lad;
            end
         end
      end
      // stay off the bus through the device turnaround
      repeat (2) @(negedge mclk);
   endtask
endmodule // fppc_host

//--- test_flash_pin_protect_control.sv
/*
 bench for the flash pin protect control, with a host model on the bus.
 assumes the design files and fppc_host.sv are compiled before it.
*/
`timescale 1ns/10ps

module test_flash_pin_protect_control;
   import fppc_pkg::*;
   logic mclk, reset_n, init_n, mode_sel, row_col_sel;
   logic top_block_lock_in, write_protect_n, core_busy;
   logic frame_n, hoe, ready_busy, mem_rd_req, prog_req;
   logic write_refused, core_reset_n, boot_device, mux_mode;
   logic [3:0] chip_identity_strap, hd, lad;
   logic [4:0] general_input_pins;
   logic [10:0] mux_addr_pins;
   logic [18:0] mux_addr;
   logic [7:0] mem_rdata;
   logic [8:0] rd;
   fppc_lad_drv_t lad_drv;
   fppc_mem_req_t mem_req;
   int err_total, compares, n_prog, n_ref, n_rd, n_oe, p, r, o, i;

   fppc_ctrl fppc_ctrl_inst (.mclk(mclk), .reset_n(reset_n),
      .init_n(init_n), .mode_sel(mode_sel),
      .chip_identity_strap(chip_identity_strap),
      .general_input_pins(general_input_pins),
      .top_block_lock_in(top_block_lock_in),
      .write_protect_n(write_protect_n), .frame_n(frame_n), .lad_in(lad),
      .lad_drv(lad_drv), .row_col_sel(row_col_sel),
      .mux_addr_pins(mux_addr_pins), .mux_addr(mux_addr),
      .ready_busy(ready_busy), .mem_req(mem_req), .mem_rd_req(mem_rd_req),
      .mem_rdata(mem_rdata), .prog_req(prog_req),
      .write_refused(write_refused), .core_busy(core_busy),
      .core_reset_n(core_reset_n), .boot_device(boot_device),
      .mux_mode(mux_mode));
   fppc_host fppc_host_inst (.mclk(mclk), .frame_n(frame_n), .hd(hd),
      .hoe(hoe), .lad(lad));

   // pull-up keeps an idle bus from reading as a sync nibble
   assign lad = lad_drv.oe ? lad_drv.data : (hoe ? hd : 4'hf);

   always #10 mclk = ~mclk;

   always @(negedge mclk)
   begin
      n_prog += (prog_req === 1'b1);
      n_ref += (write_refused === 1'b1);
      n_rd += (mem_rd_req === 1'b1);
      n_oe += (lad_drv.oe === 1'b1);
   end

   task automatic chk(input string n, input logic [18:0] e,
      input logic [18:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic wrap_up;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [31:0] mk(input logic [3:0] id,
      input logic [2:0] b);
      return {5'h0, id, 4'h0, b, 16'h1234};
   endfunction

   task automatic rst;
      reset_n = 1'b0;
      repeat (20) @(negedge mclk);
      reset_n = 1'b1;
      repeat (5) @(negedge mclk);
   endtask

   task automatic t_read;
      r = n_rd;
      fppc_host_inst.cyc(1'b0, mk(4'h0, 3'h3), 8'h0, 99, rd);
      chk("rdata", 19'h1a6, {10'h0, rd});
      chk("rd_req", 19'h1, 19'(n_rd - r));
   endtask

   task automatic t_prot;
      for (i = 0; i < 4; i++)
      begin
         top_block_lock_in = i[0];
         write_protect_n = ~i[0];
         p = n_prog;
         r = n_ref;
         fppc_host_inst.cyc(1'b1, mk(4'h0, i[1] ? 3'h2 : 3'h7), 8'h3c,
            99, rd);
         chk("prog", 19'(i[0] ^ i[1]), 19'(n_prog - p));
         chk("refused", {18'h0, ~(i[0] ^ i[1])}, 19'(n_ref - r));
      end
      chk("wdata", 19'h3c, {11'h0, mem_req.data});
      chk("waddr", 19'h21234, mem_req.addr);
   endtask

   task automatic t_gpi;
      // inputs held across the whole read
      general_input_pins = 5'h15;
      r = n_rd;
      fppc_host_inst.cyc(1'b0, 32'h0040_0080, 8'h0, 99, rd);
      chk("gpi", 19'h115, {10'h0, rd});
      chk("gpi_rd_req", 19'h0, 19'(n_rd - r));
   endtask

   task automatic t_abort;
      core_busy = 1'b1;
      o = n_oe;
      fppc_host_inst.cyc(1'b0, mk(4'h0, 3'h1), 8'h0, 3, rd);
      repeat (12) @(negedge mclk);
      chk("abort_oe", 19'h0, 19'(n_oe - o));
      chk("core_rst", 19'h1, {18'h0, core_reset_n});
      chk("rb_bus", 19'h1, {18'h0, ready_busy});
      core_busy = 1'b0;
      t_read();
   endtask

   task automatic t_id;
      chk("boot", 19'h1, {18'h0, boot_device});
      chip_identity_strap = 4'h3;
      rst();
      chk("not_boot", 19'h0, {18'h0, boot_device});
      fppc_host_inst.cyc(1'b0, mk(4'h5, 3'h3), 8'h0, 99, rd);
      chk("other_id", 19'h0, {18'h0, rd[8]});
      fppc_host_inst.cyc(1'b0, mk(4'h3, 3'h3), 8'h0, 99, rd);
      chk("own_id", 19'h1a6, {10'h0, rd});
   endtask

   task automatic t_init;
      init_n = 1'b0;
      repeat (3) @(negedge mclk);
      chk("init", 19'h0, {18'h0, core_reset_n});
      init_n = 1'b1;
      repeat (5) @(negedge mclk);
      chk("init_end", 19'h1, {18'h0, core_reset_n});
   endtask

   task automatic t_mux;
      mode_sel = 1'b1;
      rst();
      chk("mux_mode", 19'h1, {18'h0, mux_mode});
      row_col_sel = 1'b1;
      mux_addr_pins = 11'h5a5;
      repeat (2) @(negedge mclk);
      row_col_sel = 1'b0;
      mux_addr_pins = 11'h0c3;
      repeat (2) @(negedge mclk);
      chk("mux_addr", 19'h61da5, mux_addr);
      core_busy = 1'b1;
      repeat (3) @(negedge mclk);
      chk("busy", 19'h0, {18'h0, ready_busy});
      core_busy = 1'b0;
      repeat (3) @(negedge mclk);
      chk("ready", 19'h1, {18'h0, ready_busy});
      mode_sel = 1'b0;
      repeat (2) @(negedge mclk);
      chk("mode_fixed", 19'h1, {18'h0, mux_mode});
      fppc_host_inst.cyc(1'b0, mk(4'h3, 3'h3), 8'h0, 99, rd);
      chk("mux_bus", 19'h0, {18'h0, rd[8]});
   endtask

   initial
   begin
      {mclk, init_n, mode_sel, row_col_sel, core_busy} = 5'h08;
      {reset_n, top_block_lock_in, write_protect_n} = 3'h3;
      {err_total, compares, n_prog, n_ref, n_rd, n_oe} = '0;
      chip_identity_strap = 4'h0;
      general_input_pins = 5'h0a;
      mux_addr_pins = 11'h0;
      mem_rdata = 8'ha6;
      rst();
      t_read();
      t_prot();
      t_gpi();
      t_abort();
      t_id();
      t_init();
      t_mux();
      wrap_up();
   end

   // whole run is a few hundred cycles
   initial
   begin
      #200000;
      err_total++;
      wrap_up();
   end
endmodule // test_flash_pin_protect_control
